//--- bench/rsch_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rsch_host_model (
	input wire logic core_clk,
	input wire logic resp_valid,
	input wire logic slow,
	output logic resp_ready
);
	int n = 0;
	// Takes each answer at once, or after a pause when slow
	always @(negedge core_clk) begin
		n = resp_valid ? n + 1 : 0;
		resp_ready <= resp_valid && (!slow || n > 3);
	end
endmodule : rsch_host_model
`default_nettype wire

//--- bench/rsch_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module remote_status_command_handler_tb_top;
	import rsch_pkg::*;
	localparam int DLY = 8;
	logic core_clk, reset, cmd_valid, cmd_ready, cmd_has_param, cmd_syntax_err;
	logic cmd_header_on, ev_run_failure, ev_device_fault, ev_queue_overflow;
	logic resp_valid, resp_ready, resp_with_header, ext_resp_grant;
	logic analysis_start, header_enable, slow;
	rsch_cmd_t cmd_code;
	logic [LEN_W-1:0] cmd_resp_len;
	logic [7:0] meas_events, comp_events, link_error_status, resp_value;
	logic [7:0] standard_event_status, status_byte;
	logic [23:0] resp_digits;
	logic [1:0] resp_ndigits;
	int err_count = 0;
	int n_tests = 0;
	int k;
	localparam int S_RDY = 0;
	localparam int S_RSP = 1;
	localparam int S_ANA = 2;
	logic hdr_exp = 1'b0;
	rsch_handler #(.ANALYSIS_DELAY(DLY)) u_rsch_handler (.core_clk, .reset, .cmd_valid,
		.cmd_ready, .cmd_code, .cmd_has_param, .cmd_syntax_err, .cmd_header_on,
		.cmd_resp_len, .ev_run_failure, .ev_device_fault, .ev_queue_overflow,
		.meas_events, .comp_events, .link_error_status, .resp_valid, .resp_ready,
		.resp_value, .resp_digits, .resp_ndigits, .resp_with_header, .ext_resp_grant,
		.analysis_start, .standard_event_status, .status_byte, .header_enable);
	rsch_host_model u_rsch_host_model (.core_clk, .resp_valid, .slow, .resp_ready);
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input string s, input logic [23:0] e, input logic [23:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask : chk
	function automatic logic sig(input int w);
		case (w)
			S_RDY: return cmd_ready;
			S_RSP: return resp_valid;
			default: return analysis_start;
		endcase
	endfunction : sig
	task automatic wt(input int w, input logic v);
		k = 0;
		while (sig(w) !== v && k < 100) begin
			@(negedge core_clk);
			k++;
		end
		if (sig(w) !== v) begin
			err_count++;
			$display("mismatch wait exp %b got %b", v, sig(w));
			give_verdict();
		end
	endtask : wt
	task automatic cmd(input logic [3:0] c, input logic p = 1'b0, input logic [9:0] l = '0);
		@(negedge core_clk);
		cmd_valid = 1'b1;
		cmd_code = rsch_cmd_t'(c);
		cmd_has_param = p;
		cmd_resp_len = l;
		wt(S_RDY, 1'b1);
		@(negedge core_clk);
		cmd_valid = 1'b0;
		cmd_has_param = 1'b0;
	endtask : cmd
	task automatic qry(input logic [3:0] c, input logic [7:0] e, input logic [23:0] d = '0,
		input logic [1:0] nd = '0);
		cmd(c);
		chk("resp_valid", 1'b1, resp_valid);
		chk("resp_value", e, resp_value);
		chk("resp_with_header", (c == RSCH_CMD_ESR_Q) ? 1'b0 : hdr_exp, resp_with_header);
		if (nd != 2'd0) begin
			chk("resp_digits", d, resp_digits);
			chk("resp_ndigits", nd, resp_ndigits);
		end
		wt(S_RSP, 1'b0);
	endtask : qry
	task automatic ev(input logic [2:0] f, input logic [7:0] m, input logic [7:0] cp);
		@(negedge core_clk);
		{ev_run_failure, ev_device_fault, ev_queue_overflow} = f;
		meas_events = m;
		comp_events = cp;
		@(negedge core_clk);
		{ev_run_failure, ev_device_fault, ev_queue_overflow} = 3'b000;
		meas_events = 8'h00;
		comp_events = 8'h00;
		@(negedge core_clk);
	endtask : ev
	initial begin
		{cmd_valid, cmd_has_param, cmd_syntax_err, cmd_header_on, slow} = 5'h00;
		{ev_run_failure, ev_device_fault, ev_queue_overflow} = 3'b000;
		cmd_code = RSCH_CMD_CLS;
		cmd_resp_len = '0;
		meas_events = 8'h00;
		comp_events = 8'h00;
		link_error_status = 8'h5a;
		reset = 1'b1;
		repeat (5) @(negedge core_clk);
		reset = 1'b0;
		chk("std", 8'h80, standard_event_status);
		cmd_header_on = 1'b1;
		cmd(RSCH_CMD_HDR_SET, 1'b1);
		chk("header_enable", 1'b1, header_enable);
		hdr_exp = 1'b1;
		cmd(RSCH_CMD_ESR_Q);
		chk("resp_value", 8'h80, resp_value);
		chk("resp_digits", 24'h313238, resp_digits);
		chk("resp_ndigits", 2'd3, resp_ndigits);
		chk("resp_with_header", 1'b0, resp_with_header);
		chk("std", 8'h00, standard_event_status);
		wt(S_RSP, 1'b0);
		qry(RSCH_CMD_HDR_Q, 8'h01, 24'h303031, 2'd1);
		$display("test query done");
		cmd(4'hf);
		cmd(RSCH_CMD_HDR_SET);
		chk("header_enable", 1'b1, header_enable);
		qry(RSCH_CMD_ESR_Q, 8'h20);
		cmd(RSCH_CMD_CLS, 1'b1);
		chk("std", 8'h20, standard_event_status);
		cmd_syntax_err = 1'b1;
		cmd(RSCH_CMD_LINK_Q);
		cmd_syntax_err = 1'b0;
		chk("resp_valid", 1'b0, resp_valid);
		ev(3'b111, 8'h0f, 8'hff);
		chk("std", 8'h3c, standard_event_status);
		chk("status_byte", 8'h23, status_byte);
		cmd(RSCH_CMD_CLS);
		chk("std", 8'h00, standard_event_status);
		chk("status_byte", 8'h00, status_byte);
		qry(RSCH_CMD_MEAS_Q, 8'h00);
		qry(RSCH_CMD_COMP_Q, 8'h00);
		$display("test errors done");
		ev(3'b000, 8'h0f, 8'hff);
		slow = 1'b1;
		qry(RSCH_CMD_MEAS_Q, 8'h0e);
		qry(RSCH_CMD_COMP_Q, 8'h7f);
		qry(RSCH_CMD_LINK_Q, 8'h5a, 24'h303930, 2'd2);
		slow = 1'b0;
		cmd(RSCH_CMD_CLS);
		chk("resp_value", 8'h5a, resp_value);
		cmd(RSCH_CMD_EXT_Q, 1'b0, 10'd300);
		chk("grant", 1'b1, ext_resp_grant);
		cmd(RSCH_CMD_EXT_Q, 1'b0, 10'd301);
		chk("grant", 1'b0, ext_resp_grant);
		chk("std", 8'h04, standard_event_status);
		cmd_header_on = 1'b0;
		cmd(RSCH_CMD_HDR_SET, 1'b1);
		hdr_exp = 1'b0;
		qry(RSCH_CMD_HDR_Q, 8'h00, 24'h303030, 2'd1);
		$display("test readout done");
		reset = 1'b1;
		repeat (2) @(negedge core_clk);
		reset = 1'b0;
		chk("std", 8'h80, standard_event_status);
		chk("header_enable", 1'b0, header_enable);
		cmd(RSCH_CMD_START);
		chk("cmd_ready", 1'b0, cmd_ready);
		wt(S_ANA, 1'b1);
		chk("latency", 24'(DLY), 24'(k));
		chk("cmd_ready", 1'b1, cmd_ready);
		$display("test start done");
		give_verdict();
	end
endmodule : remote_status_command_handler_tb_top
`default_nettype wire

//--- design/rsch_handler.sv
`timescale 1ns/1ps
`default_nettype none
module rsch_handler #(
	parameter int ANALYSIS_DELAY = rsch_pkg::LAT_MIN_CYC
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire rsch_pkg::rsch_cmd_t cmd_code,
	input wire logic cmd_has_param,
	input wire logic cmd_syntax_err,
	input wire logic cmd_header_on,
	input wire logic [rsch_pkg::LEN_W-1:0] cmd_resp_len,
	input wire logic ev_run_failure,
	input wire logic ev_device_fault,
	input wire logic ev_queue_overflow,
	input wire logic [7:0] meas_events,
	input wire logic [7:0] comp_events,
	input wire logic [7:0] link_error_status,
	output logic resp_valid,
	input wire logic resp_ready,
	output logic [7:0] resp_value,
	output logic [23:0] resp_digits,
	output logic [1:0] resp_ndigits,
	output logic resp_with_header,
	output logic ext_resp_grant,
	output logic analysis_start,
	output logic [7:0] standard_event_status,
	output logic [7:0] status_byte,
	output logic header_enable
);
	import rsch_pkg::*;

	rsch_state_t state_q, state_d;
	logic [7:0] ses_q, ses_d;
	logic [7:0] meas_q, meas_d;
	logic [7:0] comp_q, comp_d;
	logic [7:0] sb_q, sb_d;
	logic hdr_q, hdr_d;
	logic [7:0] rval_q, rval_d;
	logic [23:0] rdig_q;
	logic [1:0] rnd_q;
	logic [23:0] dig_w;
	logic [1:0] nd_w;
	logic rhdr_q, rhdr_d;
	logic grant_q, grant_d;
	logic start_q, start_d;
	logic [LAT_W-1:0] cnt_q, cnt_d;
	logic accept;
	logic bad;
	logic [7:0] ses_set;
	logic [7:0] ses_clr;
	logic meas_clr;
	logic comp_clr;
	rsch_nr1 u_nr1 (
		.value(rval_d),
		.digits(dig_w),
		.ndigits(nd_w)
	);
	assign cmd_ready = (state_q == RSCH_IDLE); // RQ16
	assign accept = cmd_valid && cmd_ready;
	assign resp_valid = (state_q == RSCH_RESP);
	assign resp_value = rval_q;
	assign resp_digits = rdig_q;
	assign resp_ndigits = rnd_q;
	assign resp_with_header = rhdr_q;
	assign ext_resp_grant = grant_q;
	assign analysis_start = start_q;
	assign standard_event_status = ses_q;
	assign status_byte = sb_q;
	assign header_enable = hdr_q;

	// Command decode, flag updates and response capture
	always_comb begin
		state_d = state_q;
		hdr_d = hdr_q;
		rval_d = rval_q;
		rhdr_d = rhdr_q;
		grant_d = 1'b0;
		start_d = 1'b0;
		cnt_d = cnt_q;
		bad = 1'b0;
		ses_set = 8'h00;
		ses_clr = 8'h00;
		meas_clr = 1'b0;
		comp_clr = 1'b0;
		ses_set[SES_EXE] = ev_run_failure;
		ses_set[SES_DDE] = ev_device_fault;
		ses_set[SES_QYE] = ev_queue_overflow; // RQ15
		unique case (state_q)
			RSCH_IDLE: begin
				if (accept) begin
					if (cmd_syntax_err) begin
						bad = 1'b1; // RQ14
					end else begin
						unique case (cmd_code)
							RSCH_CMD_CLS: begin
								if (cmd_has_param) begin
									bad = 1'b1; // RQ4
								end else begin
									ses_clr = 8'hff; // RQ1
									meas_clr = 1'b1; // RQ1
									comp_clr = 1'b1; // RQ1
								end
							end
							RSCH_CMD_ESR_Q, RSCH_CMD_MEAS_Q, RSCH_CMD_COMP_Q,
							RSCH_CMD_LINK_Q, RSCH_CMD_HDR_Q: begin
								if (cmd_has_param) begin
									bad = 1'b1; // RQ14
								end else begin
									state_d = RSCH_RESP;
									rhdr_d = hdr_q;
									unique case (cmd_code)
										RSCH_CMD_ESR_Q: begin
											rval_d = ses_q; // RQ5
											rhdr_d = 1'b0; // RQ7
											ses_clr = 8'hff; // RQ6
										end
										RSCH_CMD_MEAS_Q: begin
											rval_d = meas_q; // RQ12
											meas_clr = 1'b1;
										end
										RSCH_CMD_COMP_Q: begin
											rval_d = comp_q; // RQ12
											comp_clr = 1'b1;
										end
										RSCH_CMD_LINK_Q: begin
											rval_d = link_error_status; // RQ11
										end
										default: begin
											rval_d = {7'h00, hdr_q}; // RQ13
										end
									endcase
								end
							end
							RSCH_CMD_HDR_SET: begin
								if (cmd_has_param) begin
									hdr_d = cmd_header_on; // RQ13
								end else begin
									bad = 1'b1; // RQ14
								end
							end
							RSCH_CMD_START: begin
								if (cmd_has_param) begin
									bad = 1'b1; // RQ14
								end else begin
									state_d = RSCH_WAIT; // RQ10
									cnt_d = LAT_W'(ANALYSIS_DELAY - 1);
								end
							end
							RSCH_CMD_EXT_Q: begin
								if (cmd_resp_len > RESP_MAX_BYTES) begin
									ses_set[SES_QYE] = 1'b1; // RQ8
								end else begin
									grant_d = 1'b1;
								end
							end
							default: begin
								bad = 1'b1; // RQ14
							end
						endcase
					end
				end
			end
			RSCH_RESP: begin
				if (resp_ready) begin
					state_d = RSCH_IDLE; // RQ3
				end
			end
			RSCH_WAIT: begin
				if (cnt_q == '0) begin
					start_d = 1'b1; // RQ10
					state_d = RSCH_IDLE;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			default: begin
				state_d = RSCH_IDLE;
			end
		endcase
		ses_set[SES_CME] = bad; // RQ14
		// Set wins over clear on every flag
		ses_d = ((ses_q & ~ses_clr) | ses_set) & SES_USED; // RQ9
		meas_d = ((meas_clr ? 8'h00 : meas_q) | meas_events) & MEAS_USED;
		comp_d = ((comp_clr ? 8'h00 : comp_q) | comp_events) & COMP_USED;
		sb_d = 8'h00;
		sb_d[SB_MEAS] = |meas_d; // RQ2
		sb_d[SB_COMP] = |comp_d; // RQ2
		sb_d[SB_ESB] = |ses_d; // RQ2
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q <= RSCH_IDLE;
			ses_q <= SES_RESET;
			meas_q <= 8'h00;
			comp_q <= 8'h00;
			sb_q <= 8'h00;
			hdr_q <= 1'b0;
			rval_q <= 8'h00;
			rdig_q <= 24'h000000;
			rnd_q <= 2'd0;
			rhdr_q <= 1'b0;
			grant_q <= 1'b0;
			start_q <= 1'b0;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			ses_q <= ses_d;
			meas_q <= meas_d;
			comp_q <= comp_d;
			sb_q <= sb_d;
			hdr_q <= hdr_d;
			rval_q <= rval_d;
			rdig_q <= dig_w;
			rnd_q <= nd_w;
			rhdr_q <= rhdr_d;
			grant_q <= grant_d;
			start_q <= start_d;
			cnt_q <= cnt_d;
		end
	end

	// Cycle count since a start command, only for checking
	logic [LAT_W-1:0] obs_q;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			obs_q <= '0;
		end else if (accept && cmd_code == RSCH_CMD_START) begin
			obs_q <= '0;
		end else if (state_q == RSCH_WAIT) begin
			obs_q <= obs_q + 1'b1;
		end
	end
	logic quiet;
	assign quiet = !ev_run_failure && !ev_device_fault && !ev_queue_overflow;
	sequence s_cls_ok;
		accept && cmd_code == RSCH_CMD_CLS && !cmd_has_param && !cmd_syntax_err && quiet;
	endsequence
	sequence s_esr_ok;
		accept && cmd_code == RSCH_CMD_ESR_Q && !cmd_has_param && !cmd_syntax_err;
	endsequence

	property p_cls_clear;
		@(posedge core_clk) disable iff (reset)
		s_cls_ok and (meas_events == 8'h00 && comp_events == 8'h00) |=>
			ses_q == 8'h00 && meas_q == 8'h00 && comp_q == 8'h00 && status_byte == 8'h00;
	endproperty
	a_cls_clear: assert property (p_cls_clear) else $error("clear-status left a flag set"); // RQ1
	property p_resp_hold;
		@(posedge core_clk) disable iff (reset)
		resp_valid && !resp_ready |=> resp_valid && $stable(resp_value) && !cmd_ready;
	endproperty
	a_resp_hold: assert property (p_resp_hold) else $error("pending response lost"); // RQ3
	property p_cls_param;
		@(posedge core_clk) disable iff (reset)
		accept && cmd_code == RSCH_CMD_CLS && cmd_has_param |=> ses_q[SES_CME];
	endproperty
	a_cls_param: assert property (p_cls_param) else $error("parameter on clear not flagged"); // RQ4
	property p_esr_answer;
		@(posedge core_clk) disable iff (reset)
		s_esr_ok |=> resp_valid && resp_value == $past(ses_q) && !resp_with_header;
	endproperty
	a_esr_answer: assert property (p_esr_answer) else $error("bad event-status answer"); // RQ5
	property p_esr_clear;
		@(posedge core_clk) disable iff (reset)
		s_esr_ok and quiet |=> ses_q == 8'h00;
	endproperty
	a_esr_clear: assert property (p_esr_clear) else $error("event status not cleared"); // RQ6
	property p_oversize;
		@(posedge core_clk) disable iff (reset)
		accept && cmd_code == RSCH_CMD_EXT_Q && !cmd_syntax_err && cmd_resp_len > RESP_MAX_BYTES
			|=> ses_q[SES_QYE] && !ext_resp_grant;
	endproperty
	a_oversize: assert property (p_oversize) else $error("oversize response not refused"); // RQ8
	property p_unused_bits;
		@(posedge core_clk) disable iff (reset)
		(ses_q & ~SES_USED) == 8'h00;
	endproperty
	a_unused_bits: assert property (p_unused_bits) else $error("unused status bit set"); // RQ9
	property p_latency;
		@(posedge core_clk) disable iff (reset)
		analysis_start |-> obs_q == LAT_W'(ANALYSIS_DELAY) && $past(state_q) == RSCH_WAIT;
	endproperty
	a_latency: assert property (p_latency) else $error("analysis start delay wrong"); // RQ10
	property p_order;
		@(posedge core_clk) disable iff (reset)
		state_q != RSCH_IDLE |=> $stable(header_enable) && $stable(ses_q[SES_CME]);
	endproperty
	a_order: assert property (p_order) else $error("command taken while busy"); // RQ16
	property p_bad_cmd;
		@(posedge core_clk) disable iff (reset)
		accept && (cmd_syntax_err || cmd_code > RSCH_CMD_EXT_Q) |=> ses_q[SES_CME] && !resp_valid;
	endproperty
	a_bad_cmd: assert property (p_bad_cmd) else $error("invalid command not flagged"); // RQ14
endmodule : rsch_handler
`default_nettype wire

//--- design/rsch_nr1.sv
`timescale 1ns/1ps
`default_nettype none
module rsch_nr1 (
	input wire logic [7:0] value,
	output logic [23:0] digits,
	output logic [1:0] ndigits
);
	logic [7:0] hun;
	logic [7:0] ten;
	logic [7:0] one;
	// Decimal digits, most significant first, in ASCII
	always_comb begin
		hun = value / 8'd100;
		ten = (value / 8'd10) % 8'd10;
		one = value % 8'd10;
		digits = {8'h30 + hun, 8'h30 + ten, 8'h30 + one};
		if (value >= 8'd100) begin
			ndigits = 2'd3;
		end else if (value >= 8'd10) begin
			ndigits = 2'd2;
		end else begin
			ndigits = 2'd1;
		end
	end
endmodule : rsch_nr1
`default_nettype wire

//--- design/rsch_pkg.sv
// What this block does
// RQ1: Clear-status command zeroes standard, measurement and comparator event registers.
// RQ2: Clear-status command also zeroes the status byte register.
// RQ3: Clear-status command leaves any pending response untouched.
// RQ4: Clear-status command carrying data parameters sets the command error flag.
// RQ5: Event-status query returns the standard register as a value 0 to 255.
// RQ6: After answering the event-status query the standard register is cleared.
// RQ7: Event-status query answer never carries a header.
// RQ8: A response longer than 300 bytes raises query error instead of delivery.
// RQ9: Standard register bits: 7 power-on, 5 command, 4 run, 3 device, 2 query.
// RQ10: Analysis starts 20 ms to 500 ms after command receipt; host tolerates it.
// RQ11: Link-error query returns the current serial error status.
// RQ12: Separate queries return the measurement and comparator event registers.
// RQ13: Header setting command switches response headers; a query reports it.
// RQ14: Invalid, unsupported or badly parameterised commands set command error.
// RQ15: Output queue overflow or loss sets the query error flag.
// RQ16: Commands are handled strictly in order, one at a time.
package rsch_pkg;
	localparam int CLK_KHZ = 200000;
	localparam int LAT_MIN_MS = 20;
	localparam int LAT_MAX_MS = 500;
	localparam int LAT_MIN_CYC = LAT_MIN_MS * CLK_KHZ;
	localparam int LAT_MAX_CYC = LAT_MAX_MS * CLK_KHZ;
	localparam int LAT_W = 27;
	localparam int LEN_W = 10;
	localparam logic [LEN_W-1:0] RESP_MAX_BYTES = 10'd300;
	localparam int SES_PON = 7;
	localparam int SES_CME = 5;
	localparam int SES_EXE = 4;
	localparam int SES_DDE = 3;
	localparam int SES_QYE = 2;
	localparam logic [7:0] SES_USED = 8'hbc;
	localparam logic [7:0] SES_RESET = 8'h80;
	localparam logic [7:0] MEAS_USED = 8'hfe;
	localparam logic [7:0] COMP_USED = 8'h7f;
	localparam int SB_MEAS = 0;
	localparam int SB_COMP = 1;
	localparam int SB_ESB = 5;
	typedef enum logic [3:0] {
		RSCH_CMD_CLS = 4'h0,
		RSCH_CMD_ESR_Q = 4'h1,
		RSCH_CMD_MEAS_Q = 4'h2,
		RSCH_CMD_COMP_Q = 4'h3,
		RSCH_CMD_LINK_Q = 4'h4,
		RSCH_CMD_HDR_SET = 4'h5,
		RSCH_CMD_HDR_Q = 4'h6,
		RSCH_CMD_START = 4'h7,
		RSCH_CMD_EXT_Q = 4'h8
	} rsch_cmd_t;
	typedef enum logic [2:0] {
		RSCH_IDLE = 3'b001,
		RSCH_RESP = 3'b010,
		RSCH_WAIT = 3'b100
	} rsch_state_t;
endpackage : rsch_pkg
